// ### bench/cov_backend_tb_top.sv
// self-checking bench for the cursor overlay and colour map stage
`timescale 1ns/1ns
module cov_backend_tb_top;
    import cov_pkg::*;
    localparam logic [23:0] FR = 24'ha53ce7;
    logic        clk_i, rst_i, cyc, stb, we, ack;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, rd, cur;
    cov_pix_t    pix;
    cov_vid_t    vid, last;
    int          n_pix, n_sent, n_fail, n_compared, cycles;
    logic [2:0]  md[7] = '{COV_MODE_MONO, COV_MODE_MONO, COV_MODE_MONO, COV_MODE_COL3, COV_MODE_COL4,
                           COV_MODE_RGB, COV_MODE_MASKED};
    logic [31:0] el[7] = '{32'h0, 32'h2, 32'h3, 32'h1, 32'h3, 32'h0011_2233, 32'h0f40_5060};
    logic [23:0] xc[7] = '{24'hc0c0c0, FR, ~FR, 24'hc0c0c1, 24'hc0c0c3, 24'h112233, 24'h455c67};

    cov_backend #(.MAP_DEPTH(256)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pix_i(pix), .cur_elem_i(cur), .vid_o(vid));
    cov_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .vid_i(vid), .last_o(last), .n_pix_o(n_pix));

    always #50 clk_i = ~clk_i;

    function automatic logic [29:0] ex(input logic m, input logic [1:0] d, input cov_rgb24_t p);
        logic [7:0] ir, ig, ib;
        {ir, ig, ib} = p;
        if (d == COV_DEPTH_16)
            {ir, ig, ib} = {3'h0, p.r[4:0], 2'h0, p.g[5:0], 3'h0, p.b[4:0]};
        if (d == COV_DEPTH_8)
            {ir, ig, ib} = {3{p.b}};
        if (m)
            return {2'h1, ir, 2'h2, ig, 2'h3, ib};
        if (d == COV_DEPTH_16)
            return {ir[4:0], 5'h0, ig[5:0], 4'h0, ib[4:0], 5'h0};
        return {ir, 2'h0, ig, 2'h0, ib, 2'h0};
    endfunction : ex

    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : ck

    // one wishbone classic cycle; held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask : bus

    // one pixel, then wait out the two-stage pipe and the sink
    task automatic px(input int h, input int v, input cov_rgb24_t c, input logic [31:0] e, input logic [29:0] x);
        @(posedge clk_i);
        pix <= '{1'b1, c, 12'(h), 12'(v), 1'b1, 1'b0};
        cur <= e;
        n_sent++;
        @(posedge clk_i);
        pix.valid <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        ck("colour", {2'h0, x}, {2'h0, last.r, last.g, last.b});
    endtask : px

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, sel, dat, cur} = '0;
        pix = '0;
        {n_sent, n_fail, n_compared, cycles} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, COV_OFS_CTRL, 0);
        ck("ctrl", COV_RST_CTRL, rd);
        bus(0, COV_OFS_SIZE, 0);
        ck("size", COV_RST_SIZE, rd);
        bus(1, 12'h300, 32'hffff_ffff);
        bus(0, 12'h300, 0);
        ck("unmapped", 32'h0, rd);
        for (int i = 0; i < 256; i++)
            bus(1, 12'h400 + 12'(4 * i), {4'h1, 8'(i), 2'h2, 8'(i), 2'h3, 8'(i)});
        bus(0, 12'h694, 0);
        ck("table", {4'h1, 8'ha5, 2'h2, 8'ha5, 2'h3, 8'ha5}, rd);
        $display("test registers done");
        for (int m = 0; m < 2; m++)
            for (int d = 0; d < 3; d++) begin
                bus(1, COV_OFS_CTRL, {29'h0, 2'(d), 1'(m)});
                px(10, 10, FR, 0, ex(1'(m), 2'(d), FR));
            end
        $display("test colour map done");
        bus(1, COV_OFS_CTRL, COV_RST_CTRL);
        bus(1, COV_OFS_BORDER, 32'h0012_3456);
        px(900, 10, FR, 0, ex(0, COV_DEPTH_24, 24'h123456));
        bus(1, COV_OFS_HBLANK, {4'h0, 12'd20, 4'h0, 12'd10});
        px(15, 10, FR, 0, 30'h0);
        ck("blank", 32'h1, {31'h0, last.blank});
        px(20, 10, FR, 0, ex(0, COV_DEPTH_24, FR));
        bus(1, COV_OFS_HBLANK, 0);
        bus(1, COV_OFS_CTRL, COV_RST_CTRL | 32'h78);
        px(10, 10, FR, 0, 30'h0);
        ck("sync", 32'h2, {29'h0, last.hsync, last.vsync, last.blank});
        $display("test border blank done");
        bus(1, COV_OFS_CTRL, COV_RST_CTRL);
        for (int k = 0; k < 4; k++)
            bus(1, COV_OFS_COLOR0 + 12'(4 * k), 32'h00c0_c0c0 + 32'(k));
        bus(1, COV_OFS_POS, {16'd50, 16'd100});
        for (int i = 0; i < 7; i++) begin
            bus(1, COV_OFS_CURSOR, {26'h0, 1'b1, COV_SIZE_32, md[i]});
            px(110, 60, FR, el[i], ex(0, COV_DEPTH_24, xc[i]));
        end
        bus(0, COV_OFS_STATUS, 0);
        ck("status", 32'h3, rd);
        for (int d = 0; d < 2; d++) begin
            bus(1, COV_OFS_CTRL, {29'h0, 2'(d), 1'b0});
            px(110, 60, FR, el[6], ex(0, 2'(d), 24'h455c67));
        end
        bus(1, COV_OFS_CTRL, COV_RST_CTRL);
        for (int s = 0; s < 3; s++) begin
            bus(1, COV_OFS_CURSOR, {26'h0, 1'b1, 2'(s), COV_MODE_MONO});
            px(99 + 32 + 16 * s, 60, FR, 0, ex(0, COV_DEPTH_24, 24'hc0c0c0));
            px(100 + 32 + 16 * s, 60, FR, 0, ex(0, COV_DEPTH_24, FR));
        end
        px(110, 49, FR, 0, ex(0, COV_DEPTH_24, FR));
        bus(1, COV_OFS_POS, {16'd50, 16'hfff0});
        px(47, 60, FR, 0, ex(0, COV_DEPTH_24, 24'hc0c0c0));
        px(48, 60, FR, 0, ex(0, COV_DEPTH_24, FR));
        bus(1, COV_OFS_CURSOR, {29'h0, COV_MODE_MONO});
        px(10, 60, FR, 0, ex(0, COV_DEPTH_24, FR));
        ck("pixels", 32'(n_sent), 32'(n_pix));
        $display("test cursor done");
        end_sim();
    end
endmodule : cov_backend_tb_top

// ### bench/cov_checker.sv
// port assertions for the cursor overlay and colour map stage
`timescale 1ns/1ns
module cov_checker #(
    parameter int MAP_DEPTH = 256
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [11:0]       wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire cov_pkg::cov_pix_t pix_i,
    input wire logic [31:0]       cur_elem_i,
    input wire cov_pkg::cov_vid_t vid_o
);
    import cov_pkg::*;
    // shadow of the control bits, followed from acked writes
    logic [6:0] ctl;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ctl <= COV_RST_CTRL[6:0];
        else if (wb_ack_o && wb_we_i && wb_adr_i == COV_OFS_CTRL && wb_sel_i[0])
            ctl <= wb_dat_i[6:0];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_valid_lat: assert property (!$past(rst_i, 2) |-> vid_o.valid == $past(pix_i.valid, 2))
        else $error("pixel valid latency wrong");
    a_blank_zero: assert property (vid_o.valid && (vid_o.blank ^ ctl[COV_CTRL_BL_POL]) |->
        {vid_o.r, vid_o.g, vid_o.b} == 30'h0) else $error("colour not zero in blank");
    a_force_blank: assert property (vid_o.valid && ctl[COV_CTRL_FBLANK] && $past(ctl[COV_CTRL_FBLANK], 3) |->
        vid_o.blank != ctl[COV_CTRL_BL_POL]) else $error("forced blank missing");
    a_hsync_pol: assert property (vid_o.valid && !$past(rst_i, 2) && $stable(ctl) |->
        vid_o.hsync == ($past(pix_i.hsync, 2) ^ ctl[COV_CTRL_HS_POL])) else $error("hsync polarity wrong");
    a_vsync_pol: assert property (vid_o.valid && !$past(rst_i, 2) && $stable(ctl) |->
        vid_o.vsync == ($past(pix_i.vsync, 2) ^ ctl[COV_CTRL_VS_POL])) else $error("vsync polarity wrong");
    a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> vid_o == '0 && !wb_ack_o && wb_dat_o == 32'h0)
        else $error("outputs not cleared by reset");
    c_blank: cover property (vid_o.valid && vid_o.blank);
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_active: cover property (vid_o.valid && !vid_o.blank);
endmodule : cov_checker

bind cov_backend cov_checker #(.MAP_DEPTH(MAP_DEPTH)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_i(pix_i), .cur_elem_i(cur_elem_i), .vid_o(vid_o));

// ### bench/cov_sink.sv
// output encoder model: takes every valid pixel of the video stream
`timescale 1ns/1ns
module cov_sink (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire cov_pkg::cov_vid_t vid_i,
    output      cov_pkg::cov_vid_t last_o,
    output      int                n_pix_o
);
    import cov_pkg::*;
    // no back-pressure: an encoder takes each pixel as it comes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_o  <= '0;
            n_pix_o <= 0;
        end else if (vid_i.valid) begin
            last_o  <= vid_i;
            n_pix_o <= n_pix_o + 1;
        end
    end
endmodule : cov_sink

// ### core/cov_backend.sv
// cursor merge, border/blank insert and colour map stage with wishbone registers
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns

module cov_backend #(
    parameter int MAP_DEPTH = 256
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [11:0]      wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output      logic [31:0]      wb_dat_o,
    output      logic             wb_ack_o,
    input  wire cov_pkg::cov_pix_t pix_i,
    input  wire logic [31:0]      cur_elem_i,
    output      cov_pkg::cov_vid_t vid_o
);
    import cov_pkg::*;

    logic [31:0] ctrl;
    logic [31:0] cursor;
    logic [31:0] pos;
    logic [23:0] color [4];
    logic [23:0] border;
    logic [31:0] hblank;
    logic [31:0] vblank;
    logic [31:0] vsize;
    logic [29:0] color_map_table [MAP_DEPTH];
    logic        cur_seen;

    logic        map_en;
    logic [1:0]  depth;
    logic [2:0]  active_pointer_mode;
    logic [1:0]  active_pointer_size;
    logic        cur_en;

    assign map_en = ctrl[COV_CTRL_MAP_EN];
    assign depth = ctrl[COV_CTRL_DEPTH +: 2];
    assign active_pointer_mode = cursor[COV_CUR_MODE +: 3];
    assign active_pointer_size = cursor[COV_CUR_SIZE +: 2];
    assign cur_en = cursor[COV_CUR_EN];

    // cursor width in pixels; unused size code falls back to smallest
    function automatic logic [16:0] cur_width(input logic [1:0] size);
        case (size)
            COV_SIZE_48: cur_width = 17'd48;
            COV_SIZE_64: cur_width = 17'd64;
            default:     cur_width = 17'd32;
        endcase
    endfunction : cur_width

    // keeps only the bits that take part at the given depth
    function automatic cov_rgb24_t depth_mask(input logic [1:0] dep, input cov_rgb24_t v);
        cov_rgb24_t m;
        m = v;
        if (dep == COV_DEPTH_8) begin
            m.r = 8'h00;
            m.g = 8'h00;
        end else if (dep == COV_DEPTH_16) begin
            m.r = {3'h0, v.r[4:0]};
            m.g = {2'h0, v.g[5:0]};
            m.b = {3'h0, v.b[4:0]};
        end
        return m;
    endfunction : depth_mask

    // replaceable combine: two-bit source codes and rgb / masked rgb
    function automatic cov_rgb24_t combine(
        input logic [2:0]  mode,
        input logic [31:0] elem,
        input cov_rgb24_t  frame,
        input logic [95:0] cols
    );
        cov_rgb24_t res;
        cov_rgb24_t cur;
        logic [1:0] code;
        code = elem[1:0];
        cur = elem[23:0];
        res = frame;
        case (mode)
            COV_MODE_MONO: begin
                case (code)
                    2'h0:    res = cols[0 +: 24];
                    2'h1:    res = cols[24 +: 24];
                    2'h2:    res = frame;
                    default: res = ~frame;
                endcase
            end
            COV_MODE_COL3: begin
                case (code)
                    2'h0:    res = cols[0 +: 24];
                    2'h1:    res = cols[24 +: 24];
                    2'h2:    res = cols[48 +: 24];
                    default: res = frame;
                endcase
            end
            COV_MODE_COL4: begin
                res = cols[code * 24 +: 24];
            end
            COV_MODE_RGB: begin
                res = cur;
            end
            COV_MODE_MASKED: begin
                res = (frame & {3{elem[31:24]}}) ^ cur;
            end
            default: res = frame;
        endcase
        return res;
    endfunction : combine

    // lookup or zero-pad into 30-bit colour
    function automatic logic [29:0] map_pixel(
        input logic       en,
        input logic [1:0] dep,
        input cov_rgb24_t d,
        input logic [29:0] er,
        input logic [29:0] eg,
        input logic [29:0] eb
    );
        logic [29:0] o;
        o = 30'h0;
        if (en) begin
            if (dep == COV_DEPTH_8) begin
                o = eb;
            end else begin
                o = {er[29:20], eg[19:10], eb[9:0]};
            end
        end else begin
            case (dep)
                COV_DEPTH_8:  o = {3{d.b, 2'h0}};
                COV_DEPTH_16: o = {d.r[4:0], 5'h00, d.g[5:0], 4'h0, d.b[4:0], 5'h00};
                default:      o = {d.r, 2'h0, d.g, 2'h0, d.b, 2'h0};
            endcase
        end
        return o;
    endfunction : map_pixel

    // coverage: signed cursor corner against counters, clipped to screen
    logic signed [16:0] ph;
    logic signed [16:0] pv;
    logic signed [16:0] cx;
    logic signed [16:0] cy;
    logic signed [16:0] cw;
    logic               on_screen;
    logic               covered;
    logic               in_hblank;
    logic               in_vblank;
    logic               blank_now;
    cov_rgb24_t         merged;

    assign ph = signed'({5'h00, pix_i.h});
    assign pv = signed'({5'h00, pix_i.v});
    assign cx = signed'({pos[15], pos[15:0]});
    assign cy = signed'({pos[31], pos[31:16]});
    assign cw = signed'(cur_width(active_pointer_size));
    assign on_screen = (pix_i.h < vsize[11:0]) && (pix_i.v < vsize[COV_HI_FIELD +: 12]);
    assign covered = cur_en && on_screen
                     && (ph >= cx) && (ph < cx + cw)
                     && (pv >= cy) && (pv < cy + cw);
    assign in_hblank = (pix_i.h >= hblank[11:0]) && (pix_i.h < hblank[COV_HI_FIELD +: 12]);
    assign in_vblank = (pix_i.v >= vblank[11:0]) && (pix_i.v < vblank[COV_HI_FIELD +: 12]);
    assign blank_now = in_hblank || in_vblank || ctrl[COV_CTRL_FBLANK];

    always_comb begin
        merged = pix_i.rgb;
        if (covered) begin
            merged = depth_mask(depth, combine(active_pointer_mode, cur_elem_i, pix_i.rgb,
                                {color[3], color[2], color[1], color[0]}));
        end
    end

    // stage one: merged pixel, border and blank flags
    cov_rgb24_t  s1_item;
    logic        s1_valid;
    logic        s1_blank;
    logic        s1_hs;
    logic        s1_vs;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_item  <= '0;
            s1_valid <= 1'b0;
            s1_blank <= 1'b1;
            s1_hs    <= 1'b0;
            s1_vs    <= 1'b0;
        end else begin
            s1_valid <= pix_i.valid;
            s1_blank <= blank_now;
            s1_hs    <= pix_i.hsync;
            s1_vs    <= pix_i.vsync;
            // border is anything outside the screen size but not blanked
            s1_item  <= on_screen ? merged : border;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_seen <= 1'b0;
        end else if (pix_i.valid) begin
            cur_seen <= covered;
        end
    end

    // stage two: table lookup, blanking and polarity
    cov_rgb24_t  idx;
    logic [29:0] look;

    always_comb begin
        idx = s1_item;
        if (depth == COV_DEPTH_16) begin
            idx = depth_mask(COV_DEPTH_16, s1_item);
        end
    end

    // contents are only meaningful once software has written them
    assign look = map_pixel(map_en, depth, s1_item, color_map_table[idx.r],
                            color_map_table[idx.g], color_map_table[idx.b]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vid_o <= '0;
        end else begin
            vid_o.valid <= s1_valid;
            {vid_o.r, vid_o.g, vid_o.b} <= s1_blank ? 30'h0 : look;
            vid_o.hsync <= s1_hs ^ ctrl[COV_CTRL_HS_POL];
            vid_o.vsync <= s1_vs ^ ctrl[COV_CTRL_VS_POL];
            vid_o.blank <= s1_blank ^ ctrl[COV_CTRL_BL_POL];
        end
    end

    // wishbone slave: one wait state, ack dropped the cycle after
    logic        req;
    logic        wr;
    logic        map_hit;
    logic [31:0] wmask;
    logic [31:0] next_rd;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // writes land on the edge that samples ack, together with the master
    assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    assign map_hit = wb_adr_i[11:10] == COV_MAP_SEL;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge_w(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
        return (old & ~m) | (nw & m);
    endfunction : merge_w

    // byte-masked write of a 24-bit colour; the top byte has no storage
    function automatic logic [23:0] merge_c(input logic [23:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
        logic [31:0] full;
        full = merge_w({8'h00, old}, nw, m);
        return full[23:0];
    endfunction : merge_c

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= COV_RST_CTRL;
            cursor <= COV_RST_CURSOR;
            pos    <= COV_RST_ZERO;
        end else if (wr && !map_hit) begin
            case (wb_adr_i)
                COV_OFS_CTRL:   ctrl   <= merge_w(ctrl, wb_dat_i, wmask) & 32'h0000_007f;
                COV_OFS_CURSOR: cursor <= merge_w(cursor, wb_dat_i, wmask) & 32'h0000_003f;
                COV_OFS_POS:    pos    <= merge_w(pos, wb_dat_i, wmask);
                default:        ;
            endcase
        end
    end

    // colour words: border and the four cursor colours
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            border <= COV_RST_ZERO[23:0];
            for (int i = 0; i < 4; i++) begin
                color[i] <= COV_RST_ZERO[23:0];
            end
        end else if (wr && !map_hit) begin
            if (wb_adr_i == COV_OFS_BORDER) begin
                border <= merge_c(border, wb_dat_i, wmask);
            end
            for (int i = 0; i < 4; i++) begin
                if (wb_adr_i == COV_OFS_COLOR0 + 12'(4 * i)) begin
                    color[i] <= merge_c(color[i], wb_dat_i, wmask);
                end
            end
        end
    end

    // screen geometry words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hblank <= COV_RST_HBLANK;
            vblank <= COV_RST_HBLANK;
            vsize  <= COV_RST_SIZE;
        end else if (wr && !map_hit) begin
            case (wb_adr_i)
                COV_OFS_HBLANK: hblank <= merge_w(hblank, wb_dat_i, wmask) & 32'h0fff_0fff;
                COV_OFS_VBLANK: vblank <= merge_w(vblank, wb_dat_i, wmask) & 32'h0fff_0fff;
                COV_OFS_SIZE:   vsize  <= merge_w(vsize, wb_dat_i, wmask) & 32'h0fff_0fff;
                default:        ;
            endcase
        end
    end

    // table has no reset; a full word write loads one entry
    always_ff @(posedge clk_i) begin
        if (wr && map_hit) begin
            color_map_table[wb_adr_i[9:2]] <= wb_dat_i[29:0];
        end
    end

    always_comb begin
        next_rd = 32'h0;
        if (map_hit) begin
            next_rd = {2'h0, color_map_table[wb_adr_i[9:2]]};
        end else begin
            case (wb_adr_i)
                COV_OFS_CTRL:   next_rd = ctrl;
                COV_OFS_CURSOR: next_rd = cursor;
                COV_OFS_POS:    next_rd = pos;
                COV_OFS_BORDER: next_rd = {8'h00, border};
                COV_OFS_HBLANK: next_rd = hblank;
                COV_OFS_VBLANK: next_rd = vblank;
                COV_OFS_SIZE:   next_rd = vsize;
                COV_OFS_STATUS: next_rd = {29'h0, s1_blank, cur_seen, covered};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (wb_adr_i == COV_OFS_COLOR0 + 12'(4 * i)) begin
                            next_rd = {8'h00, color[i]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= next_rd;
        end
    end
endmodule : cov_backend

// ### core/cov_pkg.sv
// constants, types and register map of the cursor overlay and colour map stage
package cov_pkg;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } cov_rgb24_t;

    typedef struct packed {
        logic       valid;
        cov_rgb24_t rgb;
        logic [11:0] h;
        logic [11:0] v;
        logic       hsync;
        logic       vsync;
    } cov_pix_t;

    typedef struct packed {
        logic       valid;
        logic [9:0] r;
        logic [9:0] g;
        logic [9:0] b;
        logic       hsync;
        logic       vsync;
        logic       blank;
    } cov_vid_t;

    localparam logic [11:0] COV_OFS_CTRL   = 12'h000;
    localparam logic [11:0] COV_OFS_CURSOR = 12'h004;
    localparam logic [11:0] COV_OFS_POS    = 12'h008;
    localparam logic [11:0] COV_OFS_COLOR0 = 12'h00c;
    localparam logic [11:0] COV_OFS_BORDER = 12'h01c;
    localparam logic [11:0] COV_OFS_HBLANK = 12'h020;
    localparam logic [11:0] COV_OFS_VBLANK = 12'h024;
    localparam logic [11:0] COV_OFS_SIZE   = 12'h028;
    localparam logic [11:0] COV_OFS_STATUS = 12'h02c;
    localparam logic [1:0]  COV_MAP_SEL    = 2'h1;

    localparam int COV_CTRL_MAP_EN  = 0;
    localparam int COV_CTRL_DEPTH   = 1;
    localparam int COV_CTRL_FBLANK  = 3;
    localparam int COV_CTRL_HS_POL  = 4;
    localparam int COV_CTRL_VS_POL  = 5;
    localparam int COV_CTRL_BL_POL  = 6;
    localparam int COV_CUR_MODE     = 0;
    localparam int COV_CUR_SIZE     = 3;
    localparam int COV_CUR_EN       = 5;
    localparam int COV_HI_FIELD     = 16;

    localparam logic [1:0] COV_DEPTH_8  = 2'h0;
    localparam logic [1:0] COV_DEPTH_16 = 2'h1;
    localparam logic [1:0] COV_DEPTH_24 = 2'h2;

    localparam logic [2:0] COV_MODE_MONO   = 3'h0;
    localparam logic [2:0] COV_MODE_COL3   = 3'h1;
    localparam logic [2:0] COV_MODE_COL4   = 3'h2;
    localparam logic [2:0] COV_MODE_RGB    = 3'h3;
    localparam logic [2:0] COV_MODE_MASKED = 3'h4;

    localparam logic [1:0] COV_SIZE_32 = 2'h0;
    localparam logic [1:0] COV_SIZE_48 = 2'h1;
    localparam logic [1:0] COV_SIZE_64 = 2'h2;

    localparam logic [31:0] COV_RST_CTRL   = 32'h0000_0004;
    localparam logic [31:0] COV_RST_CURSOR = 32'h0000_0000;
    localparam logic [31:0] COV_RST_ZERO   = 32'h0000_0000;
    localparam logic [31:0] COV_RST_HBLANK = 32'h0000_0000;
    localparam logic [31:0] COV_RST_SIZE   = 32'h0258_0320;
endpackage : cov_pkg
